//--- src/op_state_sequencer.sv
// seven-state operation mode sequencer of the ecu supply chip
// Function
// RULE1 - seven states: sleep, ramp, normal, afterrun, ar reset, down, clear
// RULE2 - sleep keeps main relay off and ecu unsupplied
// RULE3 - power-on reset clears logic; sleep stays when ignition and wake low
// RULE4 - power-on reset then ramp-up when ignition or wake high
// RULE5 - sleep goes to ramp-up on ignition high or wake
// RULE6 - ramp-up returns to sleep on ignition low and no wake
// RULE7 - ramp-up to wake clear: ignition low, wake, ramp timer overflow
// RULE8 - ramp-up to normal once 5 V rail good with ignition or wake
// RULE9 - normal to afterrun on ignition low, afterrun enabled, config kept
// RULE10 - normal to sleep: afterrun disabled, ignition low, no wake
// RULE11 - normal to power-down: ignition low with counter or shutoff overflow
// RULE12 - afterrun to power-down on counter or shutoff overflow, always
// RULE13 - afterrun to sleep when host clears enable, ignition low, no wake
// RULE14 - afterrun to normal without reset on ignition high, reset select 0
// RULE15 - afterrun to afterrun reset on ignition high, reset select 1
// RULE16 - afterrun reset lasts one cycle, then normal unconditionally
// RULE17 - power-down: supplies off, timer runs, relay held, outputs off
// RULE18 - wake clear runs configured action, resets latched wake signals
// RULE19 - wake start-up: external supply must ramp before ramp timer overflow
// RULE20 - power-down to wake clear on power-down timer overflow
// RULE21 - wake clear to sleep when ignition low
// RULE22 - wake clear to ramp-up when ignition high
// RULE23 - combined wake is pin, bus and engine-off timer wake ORed
// RULE24 - all conditions synchronised to the clock before evaluation
//
// Added by the designer: strobed register access and the register addresses.
module op_state_sequencer (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire op_seq_pkg::condIn_t           condPins,
    input  wire op_seq_pkg::regReq_t           req,
    output logic [op_seq_pkg::DATA_W-1:0]      rdata,
    output op_seq_pkg::supplyCtl_t             ctl,
    output logic [op_seq_pkg::WAKE_CLEAR_SETTING_W-1:0]     wakeClearMode,
    output op_seq_pkg::opState_t               opState
);
    import op_seq_pkg::*;

    // ****************************************************************
    // state record
    // ****************************************************************
    typedef struct packed {
        opState_t              state;
        supplyCtl_t            ctl;
        logic [WAKE_SRC_N-1:0] wakeSeen;
    } seqState_t;

    seqState_t         q;
    seqState_t         d;
    condIn_t           c;
    opConfig_t         cfg;
    logic [DATA_W-1:0] statusWord;
    logic              wakeNow;

    // ****************************************************************
    // condition inputs and registers
    // ****************************************************************
    // pins come from other supply domains, hence two flops each
    sync_bank #(
        .WIDTH (COND_W)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (condPins),
        .dout    (c)                                        // RULE24
    );

    op_regs u_regs (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .req        (req),
        .statusWord (statusWord),
        .cfg        (cfg),
        .rdata      (rdata)
    );

    assign statusWord = DATA_W'({q.wakeSeen, q.ctl.mainRelayOn, q.state});

    // ****************************************************************
    // per-state outputs
    // ****************************************************************
    function automatic supplyCtl_t ctlFor(input opState_t s,
                                          input logic     relayNow);
        supplyCtl_t r;
        r = CTL_RESET;
        unique case (s)
            ST_SLEEP: begin
                r.mainRelayOn = 1'b0;                        // RULE2
            end
            ST_RAMP: begin
                r.mainRelayOn    = 1'b1;
                r.ecuSupplyEn    = 1'b1;
                r.sensorSupplyEn = 1'b1;
            end
            ST_NORMAL, ST_AFTERRUN: begin
                r.mainRelayOn    = 1'b1;
                r.ecuSupplyEn    = 1'b1;
                r.sensorSupplyEn = 1'b1;
                r.extFuncEn      = 1'b1;
            end
            ST_AR_RESET: begin
                r.mainRelayOn        = 1'b1;
                r.ecuSupplyEn        = 1'b1;
                r.sensorSupplyEn     = 1'b1;
                r.afterrunResetPulse = 1'b1;
            end
            ST_POWERDOWN: begin
                // relay stays where it was so the ecu can drain
                r.mainRelayOn = relayNow;                    // RULE17
                r.pdTimerRun  = 1'b1;                        // RULE17
            end
            ST_WAKE_CLEAR: begin
                r.mainRelayOn    = relayNow;
                r.wakeClearPulse = 1'b1;                     // RULE18
            end
        endcase
        return r;
    endfunction

    // ****************************************************************
    // transition logic
    // ****************************************************************
    always_comb begin
        d       = q;
        wakeNow = combinedWake(c);                           // RULE23
        // a wake arriving in the clearing cycle is kept
        d.wakeSeen = ((q.state == ST_WAKE_CLEAR) ? '0 : q.wakeSeen)
                   | {c.wakePin, c.busWake, c.eotWake};      // RULE18
        unique case (q.state)                                // RULE1
            ST_SLEEP: begin
                // reset lands here; sync flops are zero until filled
                if (c.ignition || wakeNow) begin
                    d.state = ST_RAMP;                 // RULE3 RULE4 RULE5
                end
            end
            ST_RAMP: begin
                if (!c.ignition && !wakeNow) begin
                    d.state = ST_SLEEP;                      // RULE6
                end else if (!c.ignition && c.rampOf) begin
                    // external rail failed to come up in time
                    d.state = ST_WAKE_CLEAR;           // RULE7 RULE19
                end else if (c.rail5vOk) begin
                    d.state = ST_NORMAL;                     // RULE8
                end
            end
            ST_NORMAL: begin
                if (!c.ignition) begin
                    if (c.pdOf || c.ssotOf) begin
                        d.state = ST_POWERDOWN;              // RULE11
                    end else if (cfg.afterrunEnable) begin
                        d.state = ST_AFTERRUN;               // RULE9
                    end else if (!wakeNow) begin
                        d.state = ST_SLEEP;                  // RULE10
                    end
                end
            end
            ST_AFTERRUN: begin
                if (c.pdOf || c.ssotOf) begin
                    d.state = ST_POWERDOWN;                  // RULE12
                end else if (c.ignition) begin
                    d.state = cfg.afterrunResetSelect
                            ? ST_AR_RESET                    // RULE15
                            : ST_NORMAL;                     // RULE14
                end else if (!cfg.afterrunEnable && !wakeNow) begin
                    d.state = ST_SLEEP;                      // RULE13
                end
            end
            ST_AR_RESET: begin
                d.state = ST_NORMAL;                         // RULE16
            end
            ST_POWERDOWN: begin
                if (c.pdtOf) begin
                    d.state = ST_WAKE_CLEAR;                 // RULE20
                end
            end
            ST_WAKE_CLEAR: begin
                d.state = c.ignition ? ST_RAMP               // RULE22
                                     : ST_SLEEP;             // RULE21
            end
        endcase
        d.ctl = ctlFor(d.state, q.ctl.mainRelayOn);
    end

    // only constants under reset; the start decision follows release
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '{state: ST_SLEEP, ctl: CTL_RESET, wakeSeen: '0}; // RULE3
        end else begin
            q <= d;
        end
    end

    assign ctl           = q.ctl;
    assign opState       = q.state;
    assign wakeClearMode = cfg.wakeClearSetting;             // RULE18

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_sleepWake;
        q.state == ST_SLEEP && (c.ignition || combinedWake(c))
            |=> q.state == ST_RAMP;
    endproperty
    a_sleepWake: assert property (p_sleepWake)                // RULE5
        else $error("sleep did not start ramp-up on a wake");

    property p_sleepOff;
        q.state == ST_SLEEP |-> !ctl.mainRelayOn && !ctl.ecuSupplyEn;
    endproperty
    a_sleepOff: assert property (p_sleepOff)                  // RULE2
        else $error("relay or supply on during sleep");

    property p_rampDrop;
        q.state == ST_RAMP && !c.ignition && !combinedWake(c)
            |=> q.state == ST_SLEEP;
    endproperty
    a_rampDrop: assert property (p_rampDrop)                  // RULE6
        else $error("ramp-up did not fall back to sleep");

    property p_rampClear;
        q.state == ST_RAMP && !c.ignition && combinedWake(c) && c.rampOf
            |=> q.state == ST_WAKE_CLEAR ##1 q.state != ST_WAKE_CLEAR;
    endproperty
    a_rampClear: assert property (p_rampClear)                // RULE7
        else $error("ramp timeout did not lead through wake clear");

    property p_rampUp;
        q.state == ST_RAMP && c.ignition && c.rail5vOk
            |=> q.state == ST_NORMAL && ctl.extFuncEn;
    endproperty
    a_rampUp: assert property (p_rampUp)                      // RULE8
        else $error("good rail did not enter normal operation");

    property p_toAfterrun;
        q.state == ST_NORMAL && !c.ignition && !c.pdOf && !c.ssotOf
            && cfg.afterrunEnable
            |=> q.state == ST_AFTERRUN && $stable(cfg);
    endproperty
    a_toAfterrun: assert property (p_toAfterrun)              // RULE9
        else $error("afterrun entry missed or config changed");

    property p_normSleep;
        q.state == ST_NORMAL && !c.ignition && !c.pdOf && !c.ssotOf
            && !cfg.afterrunEnable && !combinedWake(c)
            |=> q.state == ST_SLEEP && !ctl.mainRelayOn;
    endproperty
    a_normSleep: assert property (p_normSleep)                // RULE10
        else $error("normal shut off did not reach sleep");

    property p_normDown;
        q.state == ST_NORMAL && !c.ignition && (c.pdOf || c.ssotOf)
            |=> q.state == ST_POWERDOWN;
    endproperty
    a_normDown: assert property (p_normDown)                  // RULE11
        else $error("normal did not power down on overflow");

    property p_afterDown;
        q.state == ST_AFTERRUN && (c.pdOf || c.ssotOf)
            |=> q.state == ST_POWERDOWN;
    endproperty
    a_afterDown: assert property (p_afterDown)                // RULE12
        else $error("afterrun did not power down on overflow");

    property p_afterSleep;
        q.state == ST_AFTERRUN && !c.pdOf && !c.ssotOf && !c.ignition
            && !cfg.afterrunEnable && !combinedWake(c)
            |=> q.state == ST_SLEEP;
    endproperty
    a_afterSleep: assert property (p_afterSleep)              // RULE13
        else $error("cleared afterrun enable did not reach sleep");

    property p_afterBack;
        q.state == ST_AFTERRUN && !c.pdOf && !c.ssotOf && c.ignition
            && !cfg.afterrunResetSelect
            |=> q.state == ST_NORMAL && !ctl.afterrunResetPulse;
    endproperty
    a_afterBack: assert property (p_afterBack)                // RULE14
        else $error("afterrun did not return directly to normal");

    property p_afterReset;
        q.state == ST_AFTERRUN && !c.pdOf && !c.ssotOf && c.ignition
            && cfg.afterrunResetSelect
            |=> ctl.afterrunResetPulse ##1
                (q.state == ST_NORMAL && !ctl.afterrunResetPulse);
    endproperty
    a_afterReset: assert property (p_afterReset)        // RULE15 RULE16
        else $error("afterrun reset was not one cycle before normal");

    property p_arResetOne;
        q.state == ST_AR_RESET
            |=> q.state == ST_NORMAL;
    endproperty
    a_arResetOne: assert property (p_arResetOne)              // RULE16
        else $error("afterrun reset lasted more than one cycle");

    property p_afterSupply;
        q.state == ST_AFTERRUN |-> ctl.mainRelayOn && ctl.ecuSupplyEn
            && ctl.sensorSupplyEn;
    endproperty
    a_afterSupply: assert property (p_afterSupply)            // RULE9
        else $error("ecu not supplied during afterrun");

    property p_downHold;
        q.state == ST_POWERDOWN |-> !ctl.ecuSupplyEn
            && !ctl.sensorSupplyEn && ctl.pdTimerRun && !ctl.extFuncEn
            && ctl.mainRelayOn == $past(ctl.mainRelayOn);
    endproperty
    a_downHold: assert property (p_downHold)                  // RULE17
        else $error("power-down outputs wrong or relay moved");

    property p_downClear;
        q.state == ST_POWERDOWN && c.pdtOf
            |=> q.state == ST_WAKE_CLEAR && ctl.wakeClearPulse;
    endproperty
    a_downClear: assert property (p_downClear)                // RULE20
        else $error("timer overflow did not enter wake clear");

    property p_wakeReset;
        q.state == ST_WAKE_CLEAR && !combinedWake(c)
            |=> q.wakeSeen == '0;
    endproperty
    a_wakeReset: assert property (p_wakeReset)                // RULE18
        else $error("latched wakes survived wake clear");

    property p_clearExit;
        q.state == ST_WAKE_CLEAR
            |=> q.state == ($past(c.ignition) ? ST_RAMP : ST_SLEEP);
    endproperty
    a_clearExit: assert property (p_clearExit)          // RULE21 RULE22
        else $error("wake clear left for the wrong state");

    c_afterrunCycle: cover property (
        q.state == ST_NORMAL ##1 q.state == ST_AFTERRUN
            ##[1:200] q.state == ST_SLEEP);
    c_arReset: cover property (q.state == ST_AR_RESET);
    c_downPath: cover property (
        q.state == ST_POWERDOWN ##[1:200] q.state == ST_WAKE_CLEAR);
    c_rampFail: cover property (
        q.state == ST_RAMP ##1 q.state == ST_WAKE_CLEAR);

endmodule // op_state_sequencer

//--- src/op_seq_pkg.sv
// shared types and constants of the operation state sequencer
package op_seq_pkg;

    // ****************************************************************
    // register bus
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CFG_ADDR  = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h04;
    localparam int CFG_AE_BIT    = 0;
    localparam int CFG_AR_BIT    = 1;
    localparam int CFG_WAKE_CLEAR_SETTING_LSB = 2;
    localparam int WAKE_CLEAR_SETTING_W       = 2;
    localparam int WAKE_SRC_N    = 3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_RAMP,
        ST_NORMAL,
        ST_AFTERRUN,
        ST_AR_RESET,
        ST_POWERDOWN,
        ST_WAKE_CLEAR
    } opState_t;

    typedef struct packed {
        logic ignition;
        logic wakePin;
        logic busWake;
        logic eotWake;
        logic rail5vOk;
        logic rampOf;
        logic pdOf;
        logic ssotOf;
        logic pdtOf;
    } condIn_t;

    localparam int COND_W = $bits(condIn_t);

    typedef struct packed {
        logic               afterrunEnable;
        logic               afterrunResetSelect;
        logic [WAKE_CLEAR_SETTING_W-1:0] wakeClearSetting;
    } opConfig_t;

    localparam opConfig_t CFG_RESET = '0;

    typedef struct packed {
        logic mainRelayOn;
        logic ecuSupplyEn;
        logic sensorSupplyEn;
        logic pdTimerRun;
        logic extFuncEn;
        logic afterrunResetPulse;
        logic wakeClearPulse;
    } supplyCtl_t;

    localparam supplyCtl_t CTL_RESET = '0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } regReq_t;

    function automatic logic combinedWake(input condIn_t c);
        return c.wakePin | c.busWake | c.eotWake;
    endfunction

endpackage

//--- src/sync_bank.sv
// two-flop synchroniser bank for asynchronous condition inputs
module sync_bank #(
    parameter int WIDTH = op_seq_pkg::COND_W
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    import op_seq_pkg::*;

    if (WIDTH < 1) begin : g_chk
        $error("sync_bank needs WIDTH of at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } syncState_t;

    syncState_t q;
    syncState_t d;

    // meta is read only by the stable stage
    always_comb begin
        d        = q;
        d.meta   = din;
        d.stable = q.meta;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.stable;

endmodule // sync_bank

//--- src/op_regs.sv
// configuration and status registers on the plain register port
module op_regs (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire op_seq_pkg::regReq_t      req,
    input  wire logic [op_seq_pkg::DATA_W-1:0] statusWord,
    output op_seq_pkg::opConfig_t         cfg,
    output logic [op_seq_pkg::DATA_W-1:0] rdata
);
    import op_seq_pkg::*;

    typedef struct packed {
        opConfig_t         cfg;
        logic [DATA_W-1:0] rdata;
    } regState_t;

    regState_t q;
    regState_t d;

    always_comb begin
        d       = q;
        d.rdata = '0;
        if (req.we && req.addr == CFG_ADDR) begin
            d.cfg.afterrunEnable      = req.wdata[CFG_AE_BIT];
            d.cfg.afterrunResetSelect = req.wdata[CFG_AR_BIT];
            d.cfg.wakeClearSetting    =
                req.wdata[CFG_WAKE_CLEAR_SETTING_LSB +: WAKE_CLEAR_SETTING_W];
        end
        // unmapped reads answer zero
        if (req.re) begin
            unique case (req.addr)
                CFG_ADDR: begin
                    d.rdata[CFG_AE_BIT]    = q.cfg.afterrunEnable;
                    d.rdata[CFG_AR_BIT]    = q.cfg.afterrunResetSelect;
                    d.rdata[CFG_WAKE_CLEAR_SETTING_LSB +: WAKE_CLEAR_SETTING_W] =
                        q.cfg.wakeClearSetting;
                end
                STAT_ADDR: d.rdata = statusWord;
                default:   d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '{cfg: CFG_RESET, rdata: '0};
        end else begin
            q <= d;
        end
    end

    assign cfg   = q.cfg;
    assign rdata = q.rdata;

endmodule // op_regs

//--- tb/supply_rail_model.sv
// supply rail and ramp timer model at the far side of the sequencer
module supply_rail_model #(
    parameter int RAIL_CYC = 4,
    parameter int RT_CYC   = 12
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic supplyEn,
    input  wire logic stuck,
    output logic      railOk,
    output logic      rampOf
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always @(posedge clk_sys or posedge rst) begin
        if (rst || !supplyEn) begin
            cnt <= 0;
        end else if (cnt < RT_CYC) begin
            cnt <= cnt + 1;
        end
    end
    // rail is good well before the ramp timer can run out
    assign railOk = supplyEn && !stuck && cnt >= RAIL_CYC;
    // stuck rail stands for a shorted supply that never ramps
    assign rampOf = supplyEn && !railOk && cnt >= RT_CYC;
endmodule // supply_rail_model

//--- tb/op_state_sequencer_tb.sv
// self-checking bench of the operation state sequencer
module op_state_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import op_seq_pkg::*;
    logic               clk_sys;
    logic               rst;
    condIn_t            pins;
    condIn_t            condAll;
    regReq_t            req;
    logic [DATA_W-1:0]  rdata;
    supplyCtl_t         ctl;
    logic [WAKE_CLEAR_SETTING_W-1:0] wakeClearMode;
    opState_t           opState;
    logic               stuck;
    logic               railOk;
    logic               rampOf;
    logic [DATA_W-1:0]  rdV;
    int                 errors;
    int                 checked;
    int                 cycles;
    always_comb begin
        condAll = pins;
        condAll.rail5vOk = railOk;
        condAll.rampOf = rampOf;
    end
    op_state_sequencer i_op_state_sequencer (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .condPins      (condAll),
        .req           (req),
        .rdata         (rdata),
        .ctl           (ctl),
        .wakeClearMode (wakeClearMode),
        .opState       (opState)
    );
    supply_rail_model i_supply_rail_model (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .supplyEn (ctl.ecuSupplyEn),
        .stuck    (stuck),
        .railOk   (railOk),
        .rampOf   (rampOf)
    );
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 4000) begin
            errors++;
            end_sim();
        end
    end
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic waitSt(input opState_t s);
        int n;
        n = 0;
        while (opState !== s && n < 40) begin
            tick(1);
            n++;
        end
        chk("opState", opState, s);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        req.wdata <= d;
        req.we <= 1'h1;
        @(posedge clk_sys);
        req.we <= 1'h0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clk_sys);
        req.addr <= a;
        req.re <= 1'h1;
        @(posedge clk_sys);
        req.re <= 1'h0;
        #1;
        rdV = rdata;
    endtask
    task automatic setIgn(input logic v);
        @(posedge clk_sys);
        pins.ignition <= v;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic tReset();
        chk("opState", opState, ST_SLEEP);
        chk("ctl", ctl, CTL_RESET);
        rd(STAT_ADDR);
        chk("status", rdV, 32'h0);
        rd(8'h08);
        chk("unmapped", rdV, 32'h0);
        wr(CFG_ADDR, 32'h8);
        tick(1);
        chk("wakeClearMode", wakeClearMode, 2'h2);
        rd(CFG_ADDR);
        chk("config", rdV, 32'h8);
    endtask
    task automatic wakeTest();
        condIn_t src;
        @(posedge clk_sys);
        stuck <= 1'h1;
        for (int i = 0; i < WAKE_SRC_N; i++) begin
            src = '0;
            src.wakePin = (i == 0);
            src.busWake = (i == 1);
            src.eotWake = (i == 2);
            @(posedge clk_sys);
            pins <= src;
            waitSt(ST_RAMP);
            @(posedge clk_sys);
            pins <= '0;
            waitSt(ST_SLEEP);
        end
    endtask
    task automatic rampFail();
        @(posedge clk_sys);
        pins.wakePin <= 1'h1;
        waitSt(ST_WAKE_CLEAR);
        chk("wakeClearPulse", ctl.wakeClearPulse, 1'h1);
        @(posedge clk_sys);
        pins.wakePin <= 1'h0;
        #1;
        chk("opState", opState, ST_SLEEP);
        tick(6);
        waitSt(ST_SLEEP);
    endtask
    task automatic normalFlow();
        @(posedge clk_sys);
        stuck <= 1'h0;
        pins.ignition <= 1'h1;
        waitSt(ST_RAMP);
        chk("mainRelayOn", ctl.mainRelayOn, 1'h1);
        waitSt(ST_NORMAL);
        chk("extFuncEn", ctl.extFuncEn, 1'h1);
        rd(STAT_ADDR);
        chk("status", rdV, 32'h4a);
        wr(CFG_ADDR, 32'h1);
        setIgn(1'h0);
        waitSt(ST_AFTERRUN);
        rd(CFG_ADDR);
        chk("config", rdV, 32'h1);
        setIgn(1'h1);
        tick(3);
        chk("opState", opState, ST_NORMAL);
        wr(CFG_ADDR, 32'h3);
        setIgn(1'h0);
        waitSt(ST_AFTERRUN);
        setIgn(1'h1);
        tick(3);
        chk("opState", opState, ST_AR_RESET);
        chk("afterrunResetPulse", ctl.afterrunResetPulse, 1'h1);
        tick(1);
        chk("opState", opState, ST_NORMAL);
        setIgn(1'h0);
        waitSt(ST_AFTERRUN);
        wr(CFG_ADDR, 32'h0);
        waitSt(ST_SLEEP);
    endtask
    task automatic powerDown();
        setIgn(1'h1);
        waitSt(ST_NORMAL);
        @(posedge clk_sys);
        pins.ignition <= 1'h0;
        pins.pdOf <= 1'h1;
        waitSt(ST_POWERDOWN);
        chk("ctl", ctl, 7'h48);
        @(posedge clk_sys);
        pins.pdOf <= 1'h0;
        pins.ignition <= 1'h1;
        pins.pdtOf <= 1'h1;
        waitSt(ST_WAKE_CLEAR);
        @(posedge clk_sys);
        pins.pdtOf <= 1'h0;
        #1;
        chk("opState", opState, ST_RAMP);
    endtask
    task automatic afterrunPd();
        waitSt(ST_NORMAL);
        wr(CFG_ADDR, 32'h1);
        setIgn(1'h0);
        waitSt(ST_AFTERRUN);
        @(posedge clk_sys);
        pins.ignition <= 1'h1;
        pins.ssotOf <= 1'h1;
        tick(3);
        chk("opState", opState, ST_POWERDOWN);
        @(posedge clk_sys);
        pins.ssotOf <= 1'h0;
        pins.pdtOf <= 1'h1;
        waitSt(ST_WAKE_CLEAR);
        @(posedge clk_sys);
        pins.pdtOf <= 1'h0;
        waitSt(ST_NORMAL);
        wr(CFG_ADDR, 32'h0);
        setIgn(1'h0);
        waitSt(ST_SLEEP);
    endtask
    task automatic porTest();
        @(posedge clk_sys);
        pins.ignition <= 1'h1;
        rst <= 1'h1;
        tick(2);
        chk("opState", opState, ST_SLEEP);
        @(posedge clk_sys);
        rst <= 1'h0;
        waitSt(ST_RAMP);
        @(posedge clk_sys);
        pins.ignition <= 1'h0;
        rst <= 1'h1;
        @(posedge clk_sys);
        rst <= 1'h0;
        tick(6);
        chk("opState", opState, ST_SLEEP);
    endtask
    task automatic end_sim();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        errors = 0;
        checked = 0;
        cycles = 0;
        pins = '0;
        req = '0;
        stuck = 1'h0;
        rst = 1'h1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        tick(1);
        tReset();
        wakeTest();
        rampFail();
        normalFlow();
        powerDown();
        afterrunPd();
        porTest();
        end_sim();
    end
endmodule // op_state_sequencer_tb
